// ### hw/fmecc_pkg.sv
// Purpose: shared constants and types of the correction and crc control block
// Assumes: byte-wide register port, one clock
// Notes: offsets are byte addresses of the register port
`default_nettype none
package fmecc_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int BUF_DEPTH = 8;
	localparam int PTR_W = 3;
	localparam int STAT_W = 5;

	localparam logic [7:0] OFF_FS_SET = 8'h1B;
	localparam logic [7:0] OFF_FS_CLR = 8'h1C;
	localparam logic [7:0] OFF_ADDR_CLR = 8'h20;
	localparam logic [7:0] OFF_DATA_PORT = 8'h21;
	localparam logic [7:0] OFF_START = 8'h22;
	localparam logic [7:0] OFF_COUNTS = 8'h23;
	localparam logic [7:0] OFF_VCRC = 8'h24;
	localparam logic [7:0] OFF_THRESH = 8'h25;
	localparam logic [7:0] OFF_L4CTL = 8'h28;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h2E;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h2F;

	localparam logic [7:0] RST_COUNTS = 8'hFB;
	localparam logic [7:0] RST_THRESH = 8'hEE;
	localparam logic [7:0] RST_VCRC = 8'h00;
	localparam logic [2:0] RST_L4_MODE = 3'h6;
	localparam logic [2:0] L4_MODE_CLEAR = 3'h7;
	localparam logic [1:0] ACLR_RESET = 2'h1;
	localparam logic [1:0] ACLR_TEST = 2'h2;

	localparam int ST_H1_DONE = 0;
	localparam int ST_V_DONE = 1;
	localparam int ST_H2_DONE = 2;
	localparam int ST_L4_ERR = 3;
	localparam int ST_FS_LOST = 4;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_H1 = 2'b01,
		SEQ_V = 2'b11,
		SEQ_H2 = 2'b10
	} fmecc_seq_state_t;
endpackage
`default_nettype wire

// ### hw/fmecc_seq.sv
// Purpose: chains first horizontal, vertical and second horizontal correction
// Assumes: done inputs are one-cycle pulses from the correction cores
// Notes: a host start while no stage is busy enters the chain at the chosen stage
`default_nettype none
module fmecc_seq (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic blk_valid_i,
	input wire logic [2:0] host_start_i,
	input wire logic [2:0] stage_done_i,
	output logic [2:0] stage_start_o,
	output logic [2:0] stage_busy_o
);
	import fmecc_pkg::*;

	typedef struct packed {
		fmecc_seq_state_t st;
		logic [2:0] start;
	} fmecc_seq_s_t;

	localparam fmecc_seq_s_t SEQ_RST = '{st: SEQ_IDLE, start: 3'h0};

	fmecc_seq_s_t s_r, s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.start = 3'h0;
		case (s_r.st)
			SEQ_IDLE: begin
				// automatic run on each block
				if (blk_valid_i || host_start_i[0]) begin
					s_nxt.st = SEQ_H1;
					s_nxt.start = 3'h1;
				end else if (host_start_i[1]) begin
					s_nxt.st = SEQ_V;
					s_nxt.start = 3'h2;
				end else if (host_start_i[2]) begin
					s_nxt.st = SEQ_H2;
					s_nxt.start = 3'h4;
				end
			end
			SEQ_H1: begin
				if (stage_done_i[0]) begin
					s_nxt.st = SEQ_V;
					s_nxt.start = 3'h2;
				end
			end
			SEQ_V: begin
				if (stage_done_i[1]) begin
					s_nxt.st = SEQ_H2;
					s_nxt.start = 3'h4;
				end
			end
			SEQ_H2: begin
				if (stage_done_i[2]) begin
					s_nxt.st = SEQ_IDLE;
				end
			end
			default: begin
				s_nxt = SEQ_RST;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s_r <= SEQ_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign stage_start_o = s_r.start;
	// stage state bits for the start register
	assign stage_busy_o = {s_r.st == SEQ_H2, s_r.st == SEQ_V, s_r.st == SEQ_H1};

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_h1_finish;
		stage_busy_o[0] && stage_done_i[0];
	endsequence
	sequence s_v_running;
		stage_start_o[1] && stage_busy_o[1];
	endsequence

	a_seq_h1_to_v: assert property (s_h1_finish |=> s_v_running)
		else $error("vertical stage did not follow first horizontal");
	a_seq_v_to_h2: assert property (stage_busy_o[1] && stage_done_i[1]
		|=> stage_start_o[2] && stage_busy_o[2])
		else $error("second horizontal stage did not follow vertical");
	a_seq_block_start: assert property (!(|stage_busy_o) && blk_valid_i
		|=> stage_start_o == 3'h1 ##1 stage_busy_o[0])
		else $error("block arrival did not start first horizontal");
endmodule
`default_nettype wire

// ### hw/fmecc_top.sv
// Purpose: register file, correction sequencing, receive ports and crc control
// Assumes: correction cores and layer-4 crc section share clk_i
// Notes: read data appear one cycle after the read strobe
`default_nettype none
//Function
//- Run the three correction stages automatically in a chain for each block that arrives while no stage is busy.
//- Deliver correction and crc outcome with data at both receive ports.
//- Any write to the force-set register makes the frame synchronized.
//- Any write to the force-clear register makes the frame unsynchronized.
//- Start register bits start each stage while no stage is busy; reads return each stage state.
//- Count register reads results, writes counts resetting to 111 and 110.
//- Vertical correction result register is read-only, resets to zero.
//- Threshold register holds first horizontal count 111 and threshold 1110.
//- Crc clear acts only when the mode bits are all ones.
//- Top bit of layer-4 control reads one on crc error.
module fmecc_top (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [fmecc_pkg::ADDR_W-1:0] addr_i,
	input wire logic [fmecc_pkg::DATA_W-1:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [fmecc_pkg::DATA_W-1:0] rd_data_o,
	input wire logic blk_valid_i,
	input wire logic [2:0] stage_done_i,
	output logic [2:0] stage_start_o,
	input wire logic [7:0] h1_data_i,
	input wire logic h1_corr_res_i,
	input wire logic h1_crc_res_i,
	input wire logic [7:0] vertical_crc_out_i,
	input wire logic [7:0] h2_data_i,
	input wire logic h2_corr_res_i,
	input wire logic h2_crc_res_i,
	output logic p1_valid_o,
	output logic [7:0] p1_data_o,
	output logic p1_corr_res_o,
	output logic p1_crc_res_o,
	output logic p2_valid_o,
	output logic [7:0] p2_data_o,
	output logic p2_corr_res_o,
	output logic p2_crc_res_o,
	output logic [2:0] h1_count_o,
	output logic [2:0] v_count_o,
	output logic [2:0] h2_count_o,
	output logic [3:0] threshold_field_o,
	output logic correction_test_change_o,
	input wire logic sync_found_i,
	input wire logic sync_lost_i,
	output logic frame_synced_o,
	input wire logic layer4_crc_error_flag_i,
	output logic crc_clear_o,
	output logic [2:0] crc_test_mode_field_o,
	output logic memory_test_bit_o,
	output logic irq_o
);
	import fmecc_pkg::*;

	typedef struct packed {
		logic [7:0] rdata;
		logic [7:0] counts;
		logic [7:0] thresh;
		logic [2:0] l4_mode;
		logic memtest;
		logic l4_clr;
		logic synced;
		logic test_chg;
		logic [7:0] vcrc;
		logic [3:0] res;
		logic p1_v;
		logic [7:0] p1_d;
		logic [1:0] p1_f;
		logic p2_v;
		logic [7:0] p2_d;
		logic [1:0] p2_f;
		logic [PTR_W-1:0] ptr;
		logic [BUF_DEPTH-1:0][7:0] cbuf;
		logic [STAT_W-1:0] stat;
		logic [STAT_W-1:0] mask;
		logic l4_prev;
	} fmecc_s_t;

	localparam fmecc_s_t TOP_RST = '{
		rdata: 8'h00, counts: RST_COUNTS, thresh: RST_THRESH, l4_mode: RST_L4_MODE,
		memtest: 1'b0, l4_clr: 1'b0, synced: 1'b0, test_chg: 1'b0, vcrc: RST_VCRC,
		res: 4'h0, p1_v: 1'b0, p1_d: 8'h00, p1_f: 2'h0, p2_v: 1'b0, p2_d: 8'h00,
		p2_f: 2'h0, ptr: '0, cbuf: '0, stat: '0, mask: '0, l4_prev: 1'b0};

	fmecc_s_t s_r, s_nxt;
	logic [2:0] busy;
	logic [2:0] host_start;
	logic [STAT_W-1:0] ev;
	logic [STAT_W-1:0] w1c;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	assign host_start = (wr_i && hit(addr_i, OFF_START)) ? wr_data_i[2:0] : 3'h0;

	fmecc_seq u_seq (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.blk_valid_i(blk_valid_i),
		.host_start_i(host_start),
		.stage_done_i(stage_done_i),
		.stage_start_o(stage_start_o),
		.stage_busy_o(busy)
	);

	always_comb begin
		s_nxt = s_r;
		s_nxt.l4_clr = 1'b0;
		s_nxt.test_chg = 1'b0;
		s_nxt.p1_v = 1'b0;
		s_nxt.p2_v = 1'b0;
		s_nxt.l4_prev = layer4_crc_error_flag_i;
		ev = '0;
		w1c = '0;
		// outcome captured with data at each receive port
		if (stage_done_i[0] && busy[0]) begin
			s_nxt.p1_v = 1'b1;
			s_nxt.p1_d = h1_data_i;
			s_nxt.p1_f = {h1_corr_res_i, h1_crc_res_i};
			s_nxt.res[2] = h1_corr_res_i;
			s_nxt.res[0] = h1_crc_res_i;
			ev[ST_H1_DONE] = 1'b1;
		end
		if (stage_done_i[1] && busy[1]) begin
			s_nxt.vcrc = vertical_crc_out_i;
			ev[ST_V_DONE] = 1'b1;
		end
		if (stage_done_i[2] && busy[2]) begin
			s_nxt.p2_v = 1'b1;
			s_nxt.p2_d = h2_data_i;
			s_nxt.p2_f = {h2_corr_res_i, h2_crc_res_i};
			s_nxt.res[3] = h2_corr_res_i;
			s_nxt.res[1] = h2_crc_res_i;
			ev[ST_H2_DONE] = 1'b1;
		end
		ev[ST_L4_ERR] = layer4_crc_error_flag_i && !s_r.l4_prev;
		// forced writes win over the synchronizer's own detection
		if (wr_i && hit(addr_i, OFF_FS_SET)) begin
			s_nxt.synced = 1'b1;
		end else if (wr_i && hit(addr_i, OFF_FS_CLR)) begin
			s_nxt.synced = 1'b0;
		end else if (sync_lost_i) begin
			s_nxt.synced = 1'b0;
		end else if (sync_found_i) begin
			s_nxt.synced = 1'b1;
		end
		ev[ST_FS_LOST] = s_r.synced && !s_nxt.synced;
		if (wr_i) begin
			if (hit(addr_i, OFF_ADDR_CLR)) begin
				if (wr_data_i[1:0] == ACLR_RESET) begin
					s_nxt.ptr = '0;
				end
				s_nxt.test_chg = (wr_data_i[1:0] == ACLR_TEST);
			end
			if (hit(addr_i, OFF_DATA_PORT)) begin
				s_nxt.cbuf[s_r.ptr] = wr_data_i;
				s_nxt.ptr = s_r.ptr + 3'h1;
			end
			if (hit(addr_i, OFF_COUNTS)) begin
				s_nxt.counts = wr_data_i;
			end
			if (hit(addr_i, OFF_THRESH)) begin
				s_nxt.thresh = wr_data_i;
			end
			if (hit(addr_i, OFF_L4CTL)) begin
				s_nxt.l4_mode = wr_data_i[7:5];
				s_nxt.memtest = wr_data_i[1];
				// clear honoured only with mode 111
				s_nxt.l4_clr = wr_data_i[0] && (wr_data_i[7:5] == L4_MODE_CLEAR);
			end
			if (hit(addr_i, OFF_IRQ_STAT)) begin
				w1c = wr_data_i[STAT_W-1:0];
			end
			if (hit(addr_i, OFF_IRQ_MASK)) begin
				s_nxt.mask = wr_data_i[STAT_W-1:0];
			end
		end
		// a new event beats a clear in the same cycle
		s_nxt.stat = (s_r.stat & ~w1c) | ev;
		s_nxt.rdata = 8'h00;
		if (rd_i) begin
			if (hit(addr_i, OFF_DATA_PORT)) begin
				s_nxt.rdata = s_r.cbuf[s_r.ptr];
				s_nxt.ptr = s_r.ptr + 3'h1;
			end else if (hit(addr_i, OFF_START)) begin
				s_nxt.rdata = {5'h00, busy};
			end else if (hit(addr_i, OFF_COUNTS)) begin
				s_nxt.rdata = {s_r.res[3:2], 4'h0, s_r.res[1:0]};
			end else if (hit(addr_i, OFF_VCRC)) begin
				s_nxt.rdata = s_r.vcrc;
			end else if (hit(addr_i, OFF_L4CTL)) begin
				s_nxt.rdata = {layer4_crc_error_flag_i, 7'h00};
			end else if (hit(addr_i, OFF_IRQ_STAT)) begin
				s_nxt.rdata = {3'h0, s_r.stat};
			end else if (hit(addr_i, OFF_IRQ_MASK)) begin
				s_nxt.rdata = {3'h0, s_r.mask};
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s_r <= TOP_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rd_data_o = s_r.rdata;
	assign p1_valid_o = s_r.p1_v;
	assign p1_data_o = s_r.p1_d;
	assign p1_corr_res_o = s_r.p1_f[1];
	assign p1_crc_res_o = s_r.p1_f[0];
	assign p2_valid_o = s_r.p2_v;
	assign p2_data_o = s_r.p2_d;
	assign p2_corr_res_o = s_r.p2_f[1];
	assign p2_crc_res_o = s_r.p2_f[0];
	assign h2_count_o = s_r.counts[7:5];
	assign v_count_o = s_r.counts[4:2];
	assign h1_count_o = s_r.thresh[7:5];
	assign threshold_field_o = s_r.thresh[3:0];
	assign correction_test_change_o = s_r.test_chg;
	assign frame_synced_o = s_r.synced;
	assign crc_clear_o = s_r.l4_clr;
	assign crc_test_mode_field_o = s_r.l4_mode;
	assign memory_test_bit_o = s_r.memtest;
	assign irq_o = |(s_r.stat & s_r.mask);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	a_fs_set_force: assert property (wr_i && addr_i == OFF_FS_SET |=> frame_synced_o)
		else $error("force set did not synchronize frame");
	a_fs_clear_force: assert property (wr_i && addr_i == OFF_FS_CLR |=> !frame_synced_o)
		else $error("force clear did not desynchronize frame");
	a_crc_clear_gate: assert property (crc_clear_o |-> $past(wr_i) && $past(addr_i) == OFF_L4CTL
		&& $past(wr_data_i[7:5]) == L4_MODE_CLEAR && $past(wr_data_i[0]))
		else $error("crc clear without mode 111");
	a_crc_clear_mode: assert property (crc_clear_o |-> crc_test_mode_field_o == L4_MODE_CLEAR)
		else $error("crc clear with wrong mode");
	a_port1_outcome: assert property (stage_done_i[0] && busy[0] && h1_crc_res_i
		|=> p1_valid_o && p1_crc_res_o ##1 !p1_valid_o)
		else $error("port one outcome not delivered");
	a_vcrc_read_back: assert property (stage_done_i[1] && busy[1] ##1 rd_i && addr_i == OFF_VCRC
		&& !(stage_done_i[1] && busy[1]) |=> rd_data_o == $past(vertical_crc_out_i, 2))
		else $error("vertical crc not read back");
	a_l4_err_read: assert property (rd_i && addr_i == OFF_L4CTL
		|=> rd_data_o == {$past(layer4_crc_error_flag_i), 7'h00})
		else $error("layer4 error flag read wrong");
	a_start_read: assert property (rd_i && addr_i == OFF_START |=> rd_data_o[2:0] == $past(busy))
		else $error("stage state read wrong");
	a_count_write: assert property (wr_i && addr_i == OFF_COUNTS
		|=> {h2_count_o, v_count_o} == $past(wr_data_i[7:2]))
		else $error("correction counts not stored");
	a_ptr_clear: assert property (wr_i && addr_i == OFF_ADDR_CLR && wr_data_i[1:0] == ACLR_RESET
		|=> s_r.ptr == '0)
		else $error("address clear did not reset pointer");
endmodule
`default_nettype wire

// ### tb/fmecc_host.sv
// Purpose: host processor model on the byte-wide register port
// Assumes: read data stand only in the cycle after the read strobe
// Notes: every strobe changes just after a rising edge
`default_nettype none
module fmecc_host (
	input wire logic clk_i,
	input wire logic [7:0] rd_data_i,
	output logic [7:0] addr_o,
	output logic [7:0] wr_data_o,
	output logic wr_o,
	output logic rd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import fmecc_pkg::*;
	initial begin
		addr_o = 8'h00;
		wr_data_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wr_data_o <= (a == OFF_L4CTL) ? (d & 8'hFD) : d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		// read data settle during the cycle after the strobe
		#1;
		d = rd_data_i;
	endtask
	// clear the crc section before a new computation
	task automatic crc_start();
		wr(OFF_L4CTL, 8'hE1);
	endtask
endmodule
`default_nettype wire

// ### tb/fmecc_top_test.sv
// Purpose: self-checking bench of the correction and crc control block
// Assumes: correction cores answer each start after eight cycles
// Notes: forced writes drive frame sync, then the sync loss and found inputs are each pulsed once
`default_nettype none
module fmecc_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import fmecc_pkg::*;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [16:0] e;} fmecc_row_t;
	logic clk_i = 1'b0, sys_rst_i = 1'b1, wr_i, rd_i, blk_valid_i = 1'b0, l4_err = 1'b0;
	logic [7:0] addr_i, wr_data_i, rd_data_o, p1_data_o, p2_data_o, v, cnt = 8'h00;
	logic [2:0] stage_done_i = 3'h0, stage_start_o, pend = 3'h0, h1c, vc, h2c, mode;
	logic [3:0] th;
	logic p1_valid_o, p1_corr, p1_crc, p2_valid_o, p2_corr, p2_crc, tchg, synced, clr, memt;
	logic irq_o, sf = 1'b0, sl = 1'b0;
	logic [7:0] h1_d = 8'h3C, vcrc_in = 8'hA5;
	int failures = 0, n_tests = 0, n_clr = 0, n_tchg = 0, n_p1 = 0, i;
	int n_st [3] = '{0, 0, 0};
	fmecc_row_t rows [9];
	fmecc_host u_fmecc_host (.clk_i(clk_i), .rd_data_i(rd_data_o), .addr_o(addr_i),
		.wr_data_o(wr_data_i), .wr_o(wr_i), .rd_o(rd_i));
	fmecc_top u_fmecc_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
		.wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
		.blk_valid_i(blk_valid_i), .stage_done_i(stage_done_i), .stage_start_o(stage_start_o),
		.h1_data_i(h1_d), .h1_corr_res_i(1'b1), .h1_crc_res_i(1'b0),
		.vertical_crc_out_i(vcrc_in), .h2_data_i(8'hC3), .h2_corr_res_i(1'b0),
		.h2_crc_res_i(1'b1), .p1_valid_o(p1_valid_o), .p1_data_o(p1_data_o),
		.p1_corr_res_o(p1_corr), .p1_crc_res_o(p1_crc), .p2_valid_o(p2_valid_o),
		.p2_data_o(p2_data_o), .p2_corr_res_o(p2_corr), .p2_crc_res_o(p2_crc),
		.h1_count_o(h1c), .v_count_o(vc), .h2_count_o(h2c), .threshold_field_o(th),
		.correction_test_change_o(tchg), .sync_found_i(sf), .sync_lost_i(sl),
		.frame_synced_o(synced), .layer4_crc_error_flag_i(l4_err), .crc_clear_o(clr),
		.crc_test_mode_field_o(mode), .memory_test_bit_o(memt), .irq_o(irq_o));
	initial begin
		forever #2 clk_i = ~clk_i;
	end
	// correction cores: done eight cycles after each start
	always @(posedge clk_i) begin
		stage_done_i <= 3'h0;
		if (|stage_start_o) begin
			pend <= stage_start_o;
			cnt <= 8'h08;
			for (int k = 0; k < 3; k++) n_st[k] += (stage_start_o[k] === 1'b1);
		end else if (cnt != 8'h00) begin
			cnt <= cnt - 8'h01;
			if (cnt == 8'h01) stage_done_i <= pend;
		end
		n_clr += (clr === 1'b1);
		n_tchg += (tchg === 1'b1);
		n_p1 += (p1_valid_o === 1'b1);
	end
	task automatic chk(input string nm, input logic [16:0] seen, input logic [16:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic step();
		repeat (2) @(posedge clk_i);
	endtask
	task automatic wait_p2();
		for (i = 0; i < 60 && p2_valid_o !== 1'b1; i++) @(posedge clk_i);
		if (i == 60) begin
			failures++;
			final_report();
		end
		@(posedge clk_i);
	endtask
	function automatic logic [16:0] outs();
		return {h2c, vc, h1c, th, mode, synced};
	endfunction
	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		final_report();
	end
	initial begin
		// configuration registers written only to check their fields
		rows = '{'{8'h1B, 8'h00, {3'h7, 3'h6, 3'h7, 4'hE, 3'h6, 1'h1}},
			'{8'h1C, 8'hFF, {3'h7, 3'h6, 3'h7, 4'hE, 3'h6, 1'h0}},
			'{8'h1B, 8'h5A, {3'h7, 3'h6, 3'h7, 4'hE, 3'h6, 1'h1}},
			'{8'h23, 8'hA4, {3'h5, 3'h1, 3'h7, 4'hE, 3'h6, 1'h1}},
			'{8'h25, 8'h53, {3'h5, 3'h1, 3'h2, 4'h3, 3'h6, 1'h1}},
			'{8'h28, 8'h40, {3'h5, 3'h1, 3'h2, 4'h3, 3'h2, 1'h1}},
			'{8'h28, 8'h20, {3'h5, 3'h1, 3'h2, 4'h3, 3'h1, 1'h1}},
			'{8'h28, 8'h00, {3'h5, 3'h1, 3'h2, 4'h3, 3'h0, 1'h1}},
			'{8'h24, 8'hFF, {3'h5, 3'h1, 3'h2, 4'h3, 3'h0, 1'h1}}};
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		step();
		chk("reset outs", outs(), {3'h7, 3'h6, 3'h7, 4'hE, 3'h6, 1'h0});
		chk("reset memtest irq", {memt, irq_o}, 17'h00000);
		u_fmecc_host.rd(OFF_VCRC, v);
		chk("vcrc reset", v, 17'h00000);
		for (int r = 0; r < 9; r++) begin
			u_fmecc_host.wr(rows[r].a, rows[r].d);
			step();
			chk("row outs", outs(), rows[r].e);
		end
		// synchronizer's own loss and detection inputs
		sl <= 1'b1;
		@(posedge clk_i);
		sl <= 1'b0;
		step();
		chk("sync lost", synced, 17'h00000);
		sf <= 1'b1;
		@(posedge clk_i);
		sf <= 1'b0;
		step();
		chk("sync found", synced, 17'h00001);
		@(posedge clk_i);
		blk_valid_i <= 1'b1;
		@(posedge clk_i);
		blk_valid_i <= 1'b0;
		wait_p2();
		chk("p1 port", {n_p1[7:0], p1_data_o, p1_corr, p1_crc}, {8'h01, 8'h3C, 2'h2});
		chk("p2 port", {p2_data_o, p2_corr, p2_crc}, {8'hC3, 2'h1});
		chk("chain starts", {n_st[0][3:0], n_st[1][3:0], n_st[2][3:0]}, 17'h00111);
		u_fmecc_host.rd(OFF_VCRC, v);
		chk("vcrc", v, 17'h000A5);
		u_fmecc_host.rd(OFF_COUNTS, v);
		chk("results", v, 17'h00042);
		u_fmecc_host.rd(OFF_IRQ_STAT, v);
		chk("status", {v, irq_o}, {8'h17, 1'b0});
		u_fmecc_host.wr(OFF_IRQ_MASK, 8'h04);
		step();
		chk("irq masked in", irq_o, 17'h00001);
		u_fmecc_host.wr(OFF_IRQ_STAT, 8'h04);
		step();
		u_fmecc_host.rd(OFF_IRQ_STAT, v);
		chk("status w1c", {v, irq_o}, {8'h13, 1'b0});
		u_fmecc_host.wr(OFF_START, 8'h02);
		u_fmecc_host.rd(OFF_START, v);
		chk("stage state", v, 17'h00002);
		wait_p2();
		chk("host start", {n_st[0][3:0], n_st[1][3:0], n_st[2][3:0]}, 17'h00122);
		u_fmecc_host.crc_start();
		step();
		chk("crc clear", {n_clr[3:0], mode}, {4'h1, 3'h7});
		u_fmecc_host.wr(OFF_L4CTL, 8'h41);
		step();
		chk("clear refused", {n_clr[3:0], mode}, {4'h1, 3'h2});
		l4_err <= 1'b1;
		u_fmecc_host.rd(OFF_L4CTL, v);
		chk("l4 error", v, 17'h00080);
		l4_err <= 1'b0;
		u_fmecc_host.rd(OFF_L4CTL, v);
		chk("l4 normal", v, 17'h00000);
		u_fmecc_host.wr(OFF_DATA_PORT, 8'h11);
		u_fmecc_host.wr(OFF_DATA_PORT, 8'h22);
		u_fmecc_host.wr(OFF_ADDR_CLR, 8'h01);
		u_fmecc_host.rd(OFF_DATA_PORT, v);
		chk("port first", v, 17'h00011);
		u_fmecc_host.rd(OFF_DATA_PORT, v);
		chk("port second", {v, n_tchg[7:0]}, {8'h22, 8'h00});
		u_fmecc_host.wr(OFF_ADDR_CLR, 8'h02);
		step();
		chk("test change", n_tchg, 17'h00001);
		u_fmecc_host.rd(8'h3F, v);
		chk("unmapped", v, 17'h00000);
		final_report();
	end
endmodule
`default_nettype wire
